// file: shared/dmau_pkg.sv
// constants and types shared by the debug memory access unit
package dmau_pkg;
	// ------------------------------------------------------------
	// register indices on the debug register port
	// ------------------------------------------------------------
	localparam logic [7:0]  DMAU_IDX_CTRL   = 8'h07;
	localparam logic [7:0]  DMAU_IDX_ADDR   = 8'h09;
	localparam logic [7:0]  DMAU_IDX_DATA   = 8'h0A;
	// ------------------------------------------------------------
	// access_control_status field positions
	// ------------------------------------------------------------
	localparam int          DMAU_GO_BIT     = 31;
	localparam int          DMAU_DIR_BIT    = 30;
	localparam int          DMAU_SIZE_HI    = 29;
	localparam int          DMAU_SIZE_LO    = 27;
	localparam int          DMAU_VIEW_HI    = 26;
	localparam int          DMAU_VIEW_LO    = 25;
	localparam int          DMAU_WRAP_BIT   = 24;
	localparam int          DMAU_PROT_BIT   = 23;
	localparam int          DMAU_TRACE_BIT  = 22;
	localparam int          DMAU_BUFC_HI    = 21;
	localparam int          DMAU_BUFC_LO    = 20;
	localparam int          DMAU_CRC_BIT    = 19;
	localparam int          DMAU_CNT_HI     = 15;
	localparam int          DMAU_CNT_LO     = 2;
	localparam int          DMAU_ERR_BIT    = 1;
	localparam int          DMAU_VALID_BIT  = 0;
	// ------------------------------------------------------------
	// field encodings and reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  DMAU_SIZE_BYTE  = 3'h0;
	localparam logic [2:0]  DMAU_SIZE_HALF  = 3'h1;
	localparam logic [2:0]  DMAU_SIZE_WORD  = 3'h2;
	localparam logic [1:0]  DMAU_VIEW_AUTO  = 2'h0;
	localparam logic [1:0]  DMAU_VIEW_CACHE = 2'h1;
	localparam logic [1:0]  DMAU_VIEW_UNC   = 2'h2;
	localparam logic [1:0]  DMAU_BUFC_OVWR  = 2'h0;
	localparam logic [1:0]  DMAU_BUFC_STOP  = 2'h1;
	localparam logic [31:0] DMAU_CRC_POLY   = 32'hEDB88320;
	localparam logic [31:0] DMAU_CRC_SEED   = 32'h00000000;
	localparam logic [31:0] DMAU_CTRL_RST   = 32'h00000000;
	localparam logic [31:0] DMAU_ADDR_RST   = 32'h00000000;
	localparam logic [31:0] DMAU_DATA_RST   = 32'h00000000;
	// access sequencer states, gray along idle -> bus -> hold
	typedef enum logic [1:0] {
		DMAU_ST_IDLE = 2'h0,
		DMAU_ST_BUS  = 2'h1,
		DMAU_ST_HOLD = 2'h3
	} dmau_state_e;
endpackage

// file: rtl/dmau_core.sv
// debug memory access unit: register port, access sequencer, checksum
`timescale 1ns/1ps
// Overview of operation
// - go starts access; device clears when finished
// - control write aborts; go restarts fresh access
// - direction zero reads, one writes
// - trace enable stores trace words in memory
// - checksum mode reads area, result in data
// - ethernet crc32, continues across blocks
// - wrapped flag set when buffer pointer wraps
// - auto view: cached reads, uncached writes
// - view codes auto, cached, uncached, reserved
// - auto view trace writes go cached
// - cached errors go to cpu, flag clear
// - uncached errors set access error flag
// - count increments; wrap to zero ends block
// - count keeps progress after an error
// - uncached error terminates remaining block at once
// - uncached bus error, busy write, zero count crc/trace error
// - reading data clears valid on non-checksum reads
// - valid/error pair never both set
// - data little endian, low bits justified
module dmau_core
	import dmau_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_clk_en,
	input  wire logic [7:0]  i_reg_index,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [31:0] i_reg_wdata,
	output logic      [31:0] o_reg_rdata,
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic             o_mem_cached,
	output logic      [2:0]  o_mem_size,
	output logic      [31:0] o_mem_addr,
	output logic      [31:0] o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic        i_mem_err,
	input  wire logic [31:0] i_mem_rdata,
	output logic             o_cpu_bus_err,
	input  wire logic        i_trace_valid,
	input  wire logic [31:0] i_trace_word,
	output logic             o_trace_ready
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	dmau_state_e  state_reg;
	logic         go_reg, dir_reg, wrap_reg, prot_reg, trace_reg, crc_reg;
	logic         err_reg, valid_reg, req_reg, we_reg, cached_reg;
	logic         cpu_err_reg, trace_rdy_reg;
	logic [2:0]   size_reg;
	logic [1:0]   view_reg, bufc_reg;
	logic [13:0]  cnt_reg, cnt_start_reg;
	logic [31:0]  addr_reg, base_reg, data_reg, rdata_reg;
	// ------------------------------------------------------------
	// checksum step: reflected crc32, most significant byte first
	// ------------------------------------------------------------
	function automatic logic [31:0] crc_word(input logic [31:0] c,
		input logic [31:0] d);
		logic [31:0] s;
		s = c;
		for (int b = 3; b >= 0; b--)
			for (int i = 0; i < 8; i++)
				s = (s >> 1) ^ ((s[0] ^ d[b*8+i]) ? DMAU_CRC_POLY : 32'h0);
		return s;
	endfunction
	// ------------------------------------------------------------
	// decode and next values
	// ------------------------------------------------------------
	// register port strobes
	wire ctrl_wr = i_reg_wr && (i_reg_index == DMAU_IDX_CTRL);
	wire addr_wr = i_reg_wr && (i_reg_index == DMAU_IDX_ADDR);
	wire data_wr = i_reg_wr && (i_reg_index == DMAU_IDX_DATA);
	wire data_rd = i_reg_rd && (i_reg_index == DMAU_IDX_DATA);
	wire busy    = state_reg != DMAU_ST_IDLE;
	// fields of an incoming control write
	wire         w_go    = i_reg_wdata[DMAU_GO_BIT];
	wire         w_dir   = i_reg_wdata[DMAU_DIR_BIT];
	wire         w_trace = i_reg_wdata[DMAU_TRACE_BIT];
	wire         w_crc   = i_reg_wdata[DMAU_CRC_BIT];
	wire [1:0]   w_view  = i_reg_wdata[DMAU_VIEW_HI:DMAU_VIEW_LO];
	wire [13:0]  w_cnt   = i_reg_wdata[DMAU_CNT_HI:DMAU_CNT_LO];
	wire         w_bad   = (w_crc || w_trace) && (w_cnt == 14'h0);
	wire         w_we    = (w_dir && !w_crc) || w_trace;
	// cached for auto reads and auto trace writes; reserved 11 uncached
	wire         w_cache = (w_view == DMAU_VIEW_CACHE) ||
		((w_view == DMAU_VIEW_AUTO) && (!w_we || w_trace));
	// a finished checksum block is extended instead of reseeded
	wire         crc_cont = crc_reg && valid_reg && !go_reg;
	// access completion and error routing
	wire         acc_done = req_reg && i_mem_ack;
	wire         hard_err = i_mem_err && !cached_reg;
	wire [13:0]  cnt_inc  = cnt_reg + 14'h1;
	wire         blk_last = (cnt_reg == 14'h0) || (cnt_inc == 14'h0);
	wire [31:0]  step     = 32'h1 << size_reg[1:0];
	// read data right justified in the data register
	wire [31:0]  rd_just  = (size_reg == DMAU_SIZE_BYTE) ?
		{24'h0, i_mem_rdata[7:0]} : (size_reg == DMAU_SIZE_HALF) ?
		{16'h0, i_mem_rdata[15:0]} : i_mem_rdata;
	wire [31:0]  crc_next = ~crc_word(~data_reg, i_mem_rdata);
	// register read mux; reserved bits read zero
	wire [31:0]  ctrl_view = {go_reg, dir_reg, size_reg, view_reg, wrap_reg,
		prot_reg, trace_reg, bufc_reg, crc_reg, 3'h0, cnt_reg,
		err_reg, valid_reg};
	wire [31:0]  rd_mux = (i_reg_index == DMAU_IDX_CTRL) ? ctrl_view :
		(i_reg_index == DMAU_IDX_ADDR) ? addr_reg :
		(i_reg_index == DMAU_IDX_DATA) ? data_reg : 32'h0;
	// ------------------------------------------------------------
	// outputs straight from flops
	// ------------------------------------------------------------
	assign o_reg_rdata   = rdata_reg;
	assign o_mem_req     = req_reg;
	assign o_mem_we      = we_reg;
	assign o_mem_cached  = cached_reg;
	assign o_mem_size    = size_reg;
	assign o_mem_addr    = addr_reg;
	assign o_mem_wdata   = data_reg;
	assign o_cpu_bus_err = cpu_err_reg;
	assign o_trace_ready = trace_rdy_reg;
	// register read data, one cycle after the strobe
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rdata_reg <= DMAU_DATA_RST;
		else if (i_clk_en && i_reg_rd)
			rdata_reg <= rd_mux;
	end
	// ------------------------------------------------------------
	// access sequencer; a control write outranks every bus event
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= DMAU_ST_IDLE;
			{go_reg, dir_reg, wrap_reg, prot_reg, trace_reg} <= 5'h0;
			{crc_reg, err_reg, valid_reg, req_reg, we_reg} <= 5'h0;
			{cached_reg, cpu_err_reg, trace_rdy_reg} <= 3'h0;
			size_reg <= DMAU_SIZE_BYTE;
			view_reg <= DMAU_VIEW_AUTO;
			bufc_reg <= DMAU_BUFC_OVWR;
			{cnt_reg, cnt_start_reg} <= 28'h0;
			{addr_reg, base_reg} <= {DMAU_ADDR_RST, DMAU_ADDR_RST};
			data_reg <= DMAU_DATA_RST;
		end
		else if (i_clk_en)
		begin
			cpu_err_reg <= 1'b0;
			// clears come first so a same-cycle set wins
			if (data_rd && !we_reg && !crc_reg)
				valid_reg <= 1'b0;
			if (data_wr && !trace_reg)
				data_reg <= i_reg_wdata;
			if (addr_wr)
				addr_reg <= i_reg_wdata;
			if (ctrl_wr)
			begin
				dir_reg   <= w_dir;
				size_reg  <= i_reg_wdata[DMAU_SIZE_HI:DMAU_SIZE_LO];
				view_reg  <= w_view;
				wrap_reg  <= i_reg_wdata[DMAU_WRAP_BIT];
				prot_reg  <= i_reg_wdata[DMAU_PROT_BIT];
				trace_reg <= w_trace;
				bufc_reg  <= i_reg_wdata[DMAU_BUFC_HI:DMAU_BUFC_LO];
				crc_reg   <= w_crc;
				cnt_reg   <= w_cnt;
				cnt_start_reg <= w_cnt;
				base_reg  <= addr_reg;
				we_reg    <= w_we;
				cached_reg <= w_cache;
				req_reg   <= 1'b0;
				trace_rdy_reg <= 1'b0;
				state_reg <= DMAU_ST_IDLE;
				go_reg    <= 1'b0;
				if (busy || (w_go && w_bad))
				begin
					err_reg   <= 1'b1;
					valid_reg <= 1'b0;
				end
				if (w_go && !w_bad)
				begin
					// fresh access after the abort
					go_reg    <= 1'b1;
					err_reg   <= 1'b0;
					valid_reg <= w_we && !w_trace;
					if (w_crc && !crc_cont)
						data_reg <= DMAU_CRC_SEED;
					if (w_trace)
					begin
						state_reg <= DMAU_ST_HOLD;
						trace_rdy_reg <= 1'b1;
					end
					else
					begin
						state_reg <= DMAU_ST_BUS;
						req_reg   <= !busy;
					end
				end
			end
			else
			begin
				case (state_reg)
					DMAU_ST_BUS:
					begin
						if (acc_done && hard_err)
						begin
							// stop now, count holds its progress
							req_reg   <= 1'b0;
							err_reg   <= 1'b1;
							valid_reg <= 1'b0;
							go_reg    <= 1'b0;
							state_reg <= DMAU_ST_IDLE;
						end
						else if (acc_done)
						begin
							cpu_err_reg <= i_mem_err;
							if (!we_reg)
								data_reg <= crc_reg ? crc_next : rd_just;
							if (cnt_reg != 14'h0)
								cnt_reg <= cnt_inc;
							if (blk_last && !trace_reg)
							begin
								req_reg   <= 1'b0;
								go_reg    <= 1'b0;
								valid_reg <= !we_reg;
								state_reg <= DMAU_ST_IDLE;
							end
							else if (trace_reg && cnt_inc == 14'h0)
							begin
								// buffer full: pointer returns to base
								req_reg  <= 1'b0;
								cnt_reg  <= cnt_start_reg;
								addr_reg <= base_reg;
								wrap_reg <= 1'b1;
								if (bufc_reg == DMAU_BUFC_OVWR)
								begin
									state_reg <= DMAU_ST_HOLD;
									trace_rdy_reg <= 1'b1;
								end
								else
								begin
									go_reg    <= 1'b0;
									valid_reg <= 1'b0;
									state_reg <= DMAU_ST_IDLE;
									trace_reg <= bufc_reg != DMAU_BUFC_STOP;
								end
							end
							else
							begin
								addr_reg <= addr_reg + step;
								// checksum streams without tool pacing
								req_reg  <= crc_reg;
								if (!crc_reg)
								begin
									state_reg <= DMAU_ST_HOLD;
									valid_reg <= !we_reg;
									trace_rdy_reg <= trace_reg;
								end
							end
						end
						else if (!req_reg)
							req_reg <= 1'b1; // late ack of old one lost
					end
					DMAU_ST_HOLD:
					begin
						// wait for trace word, data read or data write
						if (trace_reg ? i_trace_valid :
							(we_reg ? data_wr : data_rd))
						begin
							if (trace_reg)
								data_reg <= i_trace_word;
							if (we_reg && !trace_reg)
								valid_reg <= 1'b1;
							trace_rdy_reg <= 1'b0;
							req_reg   <= 1'b1;
							state_reg <= DMAU_ST_BUS;
						end
					end
					default:
						state_reg <= DMAU_ST_IDLE;
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	AST_GO_DONE: assert property (i_clk_en && !ctrl_wr && acc_done &&
		!hard_err && blk_last && !trace_reg |=> !go_reg && !o_mem_req)
		else $error("go not cleared after final access");
	AST_ABORT: assert property (i_clk_en && ctrl_wr && busy && !w_go
		|=> err_reg && !o_mem_req && !go_reg)
		else $error("busy control write did not abort");
	AST_DIR_WE: assert property (o_mem_req && !trace_reg |->
		o_mem_we == (dir_reg && !crc_reg))
		else $error("write enable disagrees with direction");
	AST_STATUS_PAIR: assert property (!(valid_reg && err_reg))
		else $error("valid and error both set");
	AST_ZERO_CNT: assert property (i_clk_en && ctrl_wr && w_go && w_bad
		|=> err_reg && !go_reg && !o_mem_req)
		else $error("zero count block not refused");
	AST_VALID_CLR: assert property (i_clk_en && data_rd && !we_reg &&
		!crc_reg && !ctrl_wr && !acc_done |=> !valid_reg)
		else $error("data read did not clear valid");
	AST_AUTO_VIEW: assert property (o_mem_req && !trace_reg &&
		view_reg == DMAU_VIEW_AUTO |-> o_mem_cached == !o_mem_we)
		else $error("auto view routed wrongly");
	AST_HARD_ERR: assert property (i_clk_en && !ctrl_wr && acc_done &&
		hard_err |=> err_reg && !go_reg && !o_mem_req ##1 !o_mem_req)
		else $error("uncached error did not terminate");
	AST_CACHED_ERR: assert property (i_clk_en && !ctrl_wr && acc_done &&
		i_mem_err && cached_reg |=> o_cpu_bus_err && !err_reg)
		else $error("cached error not routed to cpu");
	AST_WRAP: assert property (i_clk_en && !ctrl_wr && acc_done &&
		trace_reg && cnt_inc == 14'h0 |=> wrap_reg && o_mem_addr == base_reg)
		else $error("trace wrap not flagged");
	AST_ABORT_GAP: assert property (i_clk_en && ctrl_wr && busy
		|=> !o_mem_req)
		else $error("restart kept the request up");
	COV_CRC_DONE: cover property (crc_reg && acc_done && blk_last ##1 valid_reg);
	COV_BLOCK_READ: cover property (state_reg == DMAU_ST_HOLD && data_rd
		##[1:20] acc_done && blk_last);
	COV_TRACE_WRAP: cover property (trace_reg && acc_done && cnt_inc == 14'h0);
	COV_ABORT: cover property (ctrl_wr && busy && w_go);
endmodule // dmau_core

// file: testbench/dmau_mem_model.sv
// memory side model answering the unit's access requests
`timescale 1ns/1ps
module dmau_mem_model
	import dmau_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [31:0] i_err_addr,
	input  wire logic [3:0]  i_delay,
	output logic             o_ack,
	output logic             o_err,
	output logic      [31:0] o_rdata,
	output logic      [31:0] o_waddr,
	output logic      [31:0] o_wdata
);
	// ----------------------------------------------------------
	// delayed answer; read data scrambles outside the ack cycle
	// ----------------------------------------------------------
	logic [3:0] wait_reg;
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wait_reg <= 4'h0;
			o_ack    <= 1'b0;
			o_err    <= 1'b0;
			o_rdata  <= 32'h0;
			o_waddr  <= 32'h0;
			o_wdata  <= 32'h0;
		end
		else
		begin
			o_ack   <= 1'b0;
			o_err   <= 1'b0;
			o_rdata <= ~o_rdata; // stale data must never look valid
			if (i_req && !o_ack && wait_reg == i_delay)
			begin
				wait_reg <= 4'h0;
				o_ack    <= 1'b1;
				o_err    <= (i_addr == i_err_addr);
				o_rdata  <= {i_addr[15:0], ~i_addr[15:0]};
				if (i_we)
				begin
					o_waddr <= i_addr;
					o_wdata <= i_wdata;
				end
			end
			else if (i_req && !o_ack)
				wait_reg <= wait_reg + 4'h1;
			else
				wait_reg <= 4'h0; // an abandoned request restarts the wait
		end
	end
endmodule // dmau_mem_model

// file: testbench/dmau_core_tb.sv
// self-checking bench for the debug memory access unit
`timescale 1ns/1ps
module dmau_core_tb;
	import dmau_pkg::*;
	logic i_clock, i_rst_b, i_reg_wr, i_reg_rd, i_trace_valid, i_clk_en;
	logic [7:0] i_reg_index;
	logic [31:0] i_reg_wdata, o_reg_rdata, o_mem_addr, o_mem_wdata;
	logic o_mem_req, o_mem_we, o_mem_cached, o_cpu_bus_err, o_trace_ready;
	logic [2:0] o_mem_size, last_size;
	logic i_mem_ack, i_mem_err, last_cached;
	logic [31:0] i_mem_rdata, err_addr, waddr, wdata, s, c;
	logic [3:0] delay;
	int bad_count, compares, cpu_err_seen;
	// ----------------------------------------------------------
	// device, memory model and access monitor
	// ----------------------------------------------------------
	dmau_core dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
		.i_reg_index(i_reg_index), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req),
		.o_mem_we(o_mem_we), .o_mem_cached(o_mem_cached),
		.o_mem_size(o_mem_size), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
		.i_mem_err(i_mem_err), .i_mem_rdata(i_mem_rdata),
		.o_cpu_bus_err(o_cpu_bus_err), .i_trace_valid(i_trace_valid),
		.i_trace_word(32'hCAFE0001), .o_trace_ready(o_trace_ready));
	dmau_mem_model mem (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .i_err_addr(err_addr), .i_delay(delay),
		.o_ack(i_mem_ack), .o_err(i_mem_err), .o_rdata(i_mem_rdata),
		.o_waddr(waddr), .o_wdata(wdata));
	// remember the qualifiers of the latest request
	always @(posedge i_clock)
	begin
		if (o_mem_req === 1'b1)
			{last_cached, last_size} <= {o_mem_cached, o_mem_size};
		if (o_cpu_bus_err === 1'b1)
			cpu_err_seen++;
	end
	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		@(negedge i_clock) {i_reg_index, i_reg_wdata, i_reg_wr} = {i, d, 1'b1};
		@(negedge i_clock) i_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, output logic [31:0] d);
		@(negedge i_clock) {i_reg_index, i_reg_rd} = {i, 1'b1};
		@(negedge i_clock) i_reg_rd = 1'b0;
		@(negedge i_clock) d = o_reg_rdata;
	endtask
	// poll status until the chosen bit reaches the wanted level
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		rd(DMAU_IDX_CTRL, s);
		while (s[b] !== v && n < 300)
		begin
			rd(DMAU_IDX_CTRL, s);
			n++;
		end
		check({31'h0, s[b]}, {31'h0, v});
	endtask
	// reflected crc over one word, most significant byte first
	task automatic crc_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
			c = (c >> 1) ^ (((c[0] ^ w[i ^ 7]) == 1'b1) ? DMAU_CRC_POLY : 32'h0);
	endtask
	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset;
		rd(DMAU_IDX_CTRL, s); check(s, DMAU_CTRL_RST);
		rd(DMAU_IDX_ADDR, s); check(s, DMAU_ADDR_RST);
		rd(DMAU_IDX_DATA, s); check(s, DMAU_DATA_RST);
		// index 08 is unmapped and reads zero
		rd(8'h08, s); check(s, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_read; // auto view word read
		wr(DMAU_IDX_ADDR, 32'h00001000);
		wr(DMAU_IDX_CTRL, 32'h90000000);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h3, 32'h1);
		check({31'h0, last_cached}, 32'h1);
		rd(DMAU_IDX_DATA, s); check(s, 32'h1000EFFF);
		rd(DMAU_IDX_CTRL, s); check(s & 32'h3, 32'h0);
		$display("test read done");
	endtask
	task automatic t_write; // uncached byte write
		wr(DMAU_IDX_DATA, 32'h0000005A);
		wr(DMAU_IDX_ADDR, 32'h00002003);
		wr(DMAU_IDX_CTRL, 32'hC4000000);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h3, 32'h0);
		check(waddr, 32'h00002003);
		check(wdata, 32'h0000005A);
		check({31'h0, last_cached}, 32'h0);
		check({29'h0, last_size}, {29'h0, DMAU_SIZE_BYTE});
		$display("test write done");
	endtask
	task automatic t_block_write; // two half-words, second given on demand
		wr(DMAU_IDX_DATA, 32'h00001234);
		wr(DMAU_IDX_ADDR, 32'h00007000);
		wr(DMAU_IDX_CTRL, 32'hC800FFF8);
		poll(DMAU_VALID_BIT, 1'b0);
		check(waddr, 32'h00007000);
		check(wdata, 32'h00001234);
		wr(DMAU_IDX_DATA, 32'h00005678);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h0000FFFF, 32'h0);
		check(waddr, 32'h00007002);
		check(wdata, 32'h00005678);
		check({29'h0, last_size}, {29'h0, DMAU_SIZE_HALF});
		check({31'h0, last_cached}, 32'h0);
		$display("test block write done");
	endtask
	task automatic t_block_err; // two-word block, second word fails
		err_addr = 32'h00003004;
		wr(DMAU_IDX_ADDR, 32'h00003000);
		wr(DMAU_IDX_CTRL, 32'h9400FFF8);
		poll(DMAU_VALID_BIT, 1'b1);
		rd(DMAU_IDX_DATA, s); check(s, 32'h3000CFFF);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h8000FFFF, 32'h0000FFFE);
		err_addr = 32'hFFFFFFFF;
		$display("test block error done");
	endtask
	task automatic t_abort; // control write during a slow access
		delay = 4'hF;
		wr(DMAU_IDX_CTRL, 32'h90000000);
		repeat (3) @(negedge i_clock);
		wr(DMAU_IDX_CTRL, 32'h10000000);
		rd(DMAU_IDX_CTRL, s); check(s & 32'h80000003, 32'h2);
		wr(DMAU_IDX_CTRL, 32'h90000000);
		repeat (3) @(negedge i_clock);
		wr(DMAU_IDX_CTRL, 32'h90000000);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h3, 32'h1);
		delay = 4'h0;
		$display("test abort done");
	endtask
	task automatic t_crc; // two words, then one more continued
		c = 32'hFFFFFFFF;
		crc_word(32'h4000BFFF);
		crc_word(32'h4004BFFB);
		wr(DMAU_IDX_ADDR, 32'h00004000);
		wr(DMAU_IDX_CTRL, 32'h9008FFF8);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h3, 32'h1);
		rd(DMAU_IDX_DATA, s); check(s, ~c);
		crc_word(32'h4008BFF7);
		wr(DMAU_IDX_ADDR, 32'h00004008);
		wr(DMAU_IDX_CTRL, 32'h9008FFFC);
		poll(DMAU_GO_BIT, 1'b0);
		rd(DMAU_IDX_DATA, s); check(s, ~c);
		$display("test checksum done");
	endtask
	task automatic t_cached_err;
		err_addr = 32'h00005000;
		wr(DMAU_IDX_ADDR, 32'h00005000);
		wr(DMAU_IDX_CTRL, 32'h92000000);
		poll(DMAU_GO_BIT, 1'b0);
		check(s & 32'h2, 32'h0);
		check(cpu_err_seen, 32'h1);
		err_addr = 32'hFFFFFFFF;
		$display("test cached error done");
	endtask
	task automatic t_trace; // one-word buffer wraps at once
		int n;
		wr(DMAU_IDX_ADDR, 32'h00006000);
		wr(DMAU_IDX_CTRL, 32'h8040FFFC);
		n = 0;
		while (o_trace_ready !== 1'b1 && n < 50)
		begin
			@(negedge i_clock);
			n++;
		end
		i_trace_valid = 1'b1;
		@(negedge i_clock) i_trace_valid = 1'b0;
		repeat (20) @(negedge i_clock);
		check(waddr, 32'h00006000);
		check(wdata, 32'hCAFE0001);
		check({31'h0, last_cached}, 32'h1);
		rd(DMAU_IDX_CTRL, s); check(s & 32'h01000000, 32'h01000000);
		wr(DMAU_IDX_CTRL, 32'h0);
		wr(DMAU_IDX_CTRL, 32'h0);
		rd(DMAU_IDX_CTRL, s); check(s & 32'h01000000, 32'h0);
		$display("test trace done");
	endtask
	task automatic t_freeze; // clock enable low holds every register
		wr(DMAU_IDX_ADDR, 32'h00007000);
		i_clk_en = 1'b0;
		wr(DMAU_IDX_ADDR, 32'h00007777);
		wr(DMAU_IDX_CTRL, 32'h90000000);
		i_clk_en = 1'b1;
		rd(DMAU_IDX_ADDR, s); check(s, 32'h00007000);
		rd(DMAU_IDX_CTRL, s); check(s & 32'h80000000, 32'h0);
		$display("test clock enable done");
	endtask
	// ----------------------------------------------------------
	// sequence, watchdog and verdict
	// ----------------------------------------------------------
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		{i_rst_b, i_reg_wr, i_reg_rd, i_trace_valid} = 4'h0;
		i_clk_en = 1'b1;
		{i_reg_index, i_reg_wdata, delay} = 44'h0;
		{bad_count, compares, cpu_err_seen} = '0;
		err_addr = 32'hFFFFFFFF;
		repeat (2) @(negedge i_clock);
		i_rst_b = 1'b1;
		t_reset;
		t_read;
		t_write;
		t_block_write;
		t_block_err;
		t_abort;
		t_crc;
		t_cached_err;
		t_trace;
		t_freeze;
		end_of_test;
	end
	initial
	begin
		#400000;
		bad_count++;
		end_of_test;
	end
endmodule // dmau_core_tb
